// ===== design/smr_defs.svh
`ifndef SMR_DEFS_SVH
`define SMR_DEFS_SVH

// ==========================================================
// register map
`define SMR_ADDR_W        3
`define SMR_ADDR_CTRL     3'h0
`define SMR_ADDR_DATA     3'h1
`define SMR_ADDR_DIVLO    3'h2
`define SMR_ADDR_DIVHI    3'h3
`define SMR_ADDR_MODE     3'h4
`define SMR_ADDR_INTC     3'h5

// ==========================================================
// receive_status_control fields
`define SMR_BIT_PORT_EN   7
`define SMR_BIT_NINE_SEL  6
`define SMR_BIT_SINGLE    5
`define SMR_BIT_CONT      4
`define SMR_BIT_OVERRUN   1
`define SMR_BIT_NINTH     0

// ==========================================================
// mode register fields
`define SMR_BIT_CLK_MODE  0
`define SMR_BIT_CLK_SRC   1
`define SMR_BIT_WIDE      2
`define SMR_BIT_HS        3

// ==========================================================
// interrupt control fields
`define SMR_BIT_RX_IE     0
`define SMR_BIT_PER_IE    1
`define SMR_BIT_GLB_IE    2
`define SMR_BIT_RX_IF     3

// ==========================================================
// reset values and counts
`define SMR_RST_BYTE      8'h00
`define SMR_RST_CHAR      9'h000
`define SMR_FIFO_FULL     2'h2
`define SMR_LAST_BIT_8    4'h7
`define SMR_LAST_BIT_9    4'h8

`endif

// ===== design/smr_pkg.sv
// ==========================================================
// shared types
package smr_pkg;
    typedef logic [7:0] smr_byte_t;
    typedef logic [8:0] smr_char_t;
    typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_WAIT} smr_link_state_t;
endpackage : smr_pkg

// ===== design/smr_link_shift.sv
`timescale 1ns/1ps
`default_nettype none
`include "smr_defs.svh"

module smr_link_shift (
    input  wire logic            link_clk_in,
    input  wire logic            sys_rst_in,
    input  wire logic            run_in,
    input  wire logic            single_in,
    input  wire logic            nine_in,
    input  wire logic            wide_in,
    input  wire logic [15:0]     div_in,
    input  wire logic            data_pin_in,
    output logic                 shift_clk_out,
    output logic                 done_tog_out,
    output smr_pkg::smr_char_t   char_out
);
    import smr_pkg::*;

    logic            rst_meta_r;
    logic            rst_r;
    logic            run_meta_r;
    logic            run_s_r;
    logic            dat_meta_r;
    logic            dat_s_r;
    smr_link_state_t state_r;
    logic [15:0]     cnt_r;
    logic [15:0]     div_r;
    logic [3:0]      bit_r;
    smr_char_t       shreg_r;
    logic            nine_r;
    logic            single_r;
    smr_char_t       shift_nxt;
    logic            last_bit;

    // ==========================================================
    // synchronisers into the link domain
    always_ff @(posedge link_clk_in) begin
        rst_meta_r <= sys_rst_in;
        rst_r      <= rst_meta_r;
        run_meta_r <= run_in;
        run_s_r    <= run_meta_r;
        dat_meta_r <= data_pin_in;
        dat_s_r    <= dat_meta_r;
    end

    // lsb first: new bit enters at the top
    assign shift_nxt = {dat_s_r, shreg_r[8:1]};
    assign last_bit  = (bit_r == (nine_r ? `SMR_LAST_BIT_9 : `SMR_LAST_BIT_8));

    // ==========================================================
    // shift clock generator and receive shift register
    always_ff @(posedge link_clk_in) begin
        if (rst_r) begin
            state_r       <= ST_IDLE;
            cnt_r         <= 16'h0000;
            div_r         <= 16'h0000;
            bit_r         <= 4'h0;
            shreg_r       <= `SMR_RST_CHAR;
            nine_r        <= 1'b0;
            single_r      <= 1'b0;
            shift_clk_out <= 1'b0;
            done_tog_out  <= 1'b0;
            char_out      <= `SMR_RST_CHAR;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    shift_clk_out <= 1'b0;
                    cnt_r         <= 16'h0000;
                    bit_r         <= 4'h0;
                    // settings are static while run is high; latch at start
                    if (run_s_r) begin
                        div_r    <= wide_in ? div_in : {8'h00, div_in[7:0]};
                        nine_r   <= nine_in;
                        single_r <= single_in;
                        state_r  <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (!run_s_r) begin
                        // stop at once, partial character dropped
                        state_r       <= ST_IDLE;
                        shift_clk_out <= 1'b0;
                    end else if (cnt_r != div_r) begin
                        cnt_r <= cnt_r + 16'h0001;
                    end else begin
                        cnt_r         <= 16'h0000;
                        shift_clk_out <= !shift_clk_out;
                        // trailing edge: sample the data line
                        if (shift_clk_out) begin
                            shreg_r <= shift_nxt;
                            bit_r   <= bit_r + 4'h1;
                            if (last_bit) begin
                                bit_r        <= 4'h0;
                                char_out     <= nine_r ? shift_nxt : {1'b0, shift_nxt[8:1]};
                                done_tog_out <= !done_tog_out;
                                if (single_r) begin
                                    state_r <= ST_WAIT;
                                end
                            end
                        end
                    end
                end
                ST_WAIT: begin
                    shift_clk_out <= 1'b0;
                    if (!run_s_r) begin
                        state_r <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // checks
    default clocking cb_link @(posedge link_clk_in); endclocking
    default disable iff (rst_r);

    property p_abort;
        (state_r == ST_SHIFT && !run_s_r) |=> (state_r == ST_IDLE && !shift_clk_out);
    endproperty
    a_abort: assert property (p_abort) else $error("partial character not dropped");

endmodule : smr_link_shift
`default_nettype wire

// ===== design/smr_sync_rx_top.sv
// ==========================================================
// Notes on behaviour
// - the shift clock is driven only with clocked mode, port enable and clock source set.
// - the interrupt output needs receive, peripheral and global enables all set.
// - nine-bit select shifts nine bits per character and keeps the ninth with it.
// - in master mode, setting single or continuous receive enable starts clocking and receiving.
// - a complete character sets the receive flag and requests an interrupt if enabled.
// - the status register shows the top character's ninth bit and the error flag.
// - reading the data register returns the low byte of the top character and pops it.
// - clearing continuous receive or port enable clears overrun; port disable also clears single receive and flushes the queue.
// - single receive takes one character then clears itself; dropping continuous aborts.
// - data is sampled on the trailing shift clock edge into a two-entry queue.
// - a third character with the queue full sets overrun, keeps the queue, stops receive.
`timescale 1ns/1ps
`default_nettype none
`include "smr_defs.svh"

module smr_sync_rx_top (
    input  wire logic                    mclk_in,
    input  wire logic                    sys_rst_in,
    input  wire logic [`SMR_ADDR_W-1:0]  reg_addr_in,
    input  wire smr_pkg::smr_byte_t      reg_wdata_in,
    input  wire logic                    reg_wr_in,
    input  wire logic                    reg_rd_in,
    output smr_pkg::smr_byte_t           reg_rdata_out,
    input  wire logic                    link_clk_in,
    input  wire logic                    data_pin_in,
    output logic                         data_pin_out,
    output logic                         data_pin_oe_out,
    input  wire logic                    shift_clock_pin_in,
    output logic                         shift_clock_pin_out,
    output logic                         shift_clock_pin_oe_out,
    output logic                         rx_irq_out
);
    import smr_pkg::*;

    // ==========================================================
    // declarations
    logic            serial_port_enable_r;
    logic            nine_bit_receive_select_r;
    logic            single_receive_enable_r;
    logic            continuous_receive_enable_r;
    logic            overrun_error_flag_r;
    logic            clocked_mode_r;
    logic            clock_source_select_r;
    logic            wide_divisor_select_r;
    logic            high_speed_baud_select_r;
    smr_byte_t       baud_divisor_low_r;
    smr_byte_t       baud_divisor_high_r;
    logic            receive_int_enable_r;
    logic            peripheral_interrupt_enable_r;
    logic            global_interrupt_enable_r;
    smr_char_t       fifo_mem_r [0:1];
    logic            head_r;
    logic [1:0]      count_r;
    logic            run_r;
    logic            tog_meta_r;
    logic            tog_s_r;
    logic            tog_d_r;
    logic            link_tog;
    smr_char_t       link_char;
    logic            arrive;
    logic            push;
    logic            pop;
    logic            ovr_set;
    logic            full;
    logic            wr_ctrl;
    logic            rd_data;
    logic            receive_int_flag;
    smr_char_t       top_char;
    smr_byte_t       rd_val;

    // address decode shared by reads and writes
    function automatic logic hit(input logic [`SMR_ADDR_W-1:0] a,
                                 input logic [`SMR_ADDR_W-1:0] sel);
        hit = (a == sel);
    endfunction : hit

    assign wr_ctrl          = reg_wr_in && hit(reg_addr_in, `SMR_ADDR_CTRL);
    assign rd_data          = reg_rd_in && hit(reg_addr_in, `SMR_ADDR_DATA);
    assign top_char         = fifo_mem_r[head_r];
    assign receive_int_flag = (count_r != 2'h0);

    // ==========================================================
    // link side engine
    smr_link_shift u_link (
        .link_clk_in   (link_clk_in),
        .sys_rst_in    (sys_rst_in),
        .run_in        (run_r),
        .single_in     (single_receive_enable_r && !continuous_receive_enable_r),
        .nine_in       (nine_bit_receive_select_r),
        .wide_in       (wide_divisor_select_r),
        .div_in        ({baud_divisor_high_r, baud_divisor_low_r}),
        .data_pin_in   (data_pin_in),
        .shift_clk_out (shift_clock_pin_out),
        .done_tog_out  (link_tog),
        .char_out      (link_char)
    );

    // ==========================================================
    // character-done toggle crossing; the character word is held
    // stable by the link until the next character completes
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            tog_meta_r <= 1'b0;
            tog_s_r    <= 1'b0;
            tog_d_r    <= 1'b0;
        end else begin
            tog_meta_r <= link_tog;
            tog_s_r    <= tog_meta_r;
            tog_d_r    <= tog_s_r;
        end
    end

    assign arrive  = (tog_s_r ^ tog_d_r) && serial_port_enable_r;
    assign pop     = rd_data && (count_r != 2'h0);
    assign full    = (count_r == `SMR_FIFO_FULL) && !pop;
    assign push    = arrive && !full && !overrun_error_flag_r;
    assign ovr_set = arrive && full && !overrun_error_flag_r;

    // ==========================================================
    // software configuration registers
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            serial_port_enable_r          <= 1'b0;
            nine_bit_receive_select_r     <= 1'b0;
            continuous_receive_enable_r   <= 1'b0;
            clocked_mode_r                <= 1'b0;
            clock_source_select_r         <= 1'b0;
            wide_divisor_select_r         <= 1'b0;
            high_speed_baud_select_r      <= 1'b0;
            baud_divisor_low_r            <= `SMR_RST_BYTE;
            baud_divisor_high_r           <= `SMR_RST_BYTE;
            receive_int_enable_r          <= 1'b0;
            peripheral_interrupt_enable_r <= 1'b0;
            global_interrupt_enable_r     <= 1'b0;
        end else if (reg_wr_in) begin
            unique case (reg_addr_in)
                `SMR_ADDR_CTRL: begin
                    serial_port_enable_r        <= reg_wdata_in[`SMR_BIT_PORT_EN];
                    nine_bit_receive_select_r   <= reg_wdata_in[`SMR_BIT_NINE_SEL];
                    continuous_receive_enable_r <= reg_wdata_in[`SMR_BIT_CONT];
                end
                `SMR_ADDR_DIVLO: baud_divisor_low_r  <= reg_wdata_in;
                `SMR_ADDR_DIVHI: baud_divisor_high_r <= reg_wdata_in;
                `SMR_ADDR_MODE: begin
                    clocked_mode_r           <= reg_wdata_in[`SMR_BIT_CLK_MODE];
                    clock_source_select_r    <= reg_wdata_in[`SMR_BIT_CLK_SRC];
                    wide_divisor_select_r    <= reg_wdata_in[`SMR_BIT_WIDE];
                    high_speed_baud_select_r <= reg_wdata_in[`SMR_BIT_HS];
                end
                `SMR_ADDR_INTC: begin
                    receive_int_enable_r          <= reg_wdata_in[`SMR_BIT_RX_IE];
                    peripheral_interrupt_enable_r <= reg_wdata_in[`SMR_BIT_PER_IE];
                    global_interrupt_enable_r     <= reg_wdata_in[`SMR_BIT_GLB_IE];
                end
                default: ;
            endcase
        end
    end

    // ==========================================================
    // single receive enable: software sets, cleared after one character
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            single_receive_enable_r <= 1'b0;
        end else if (wr_ctrl) begin
            single_receive_enable_r <= reg_wdata_in[`SMR_BIT_SINGLE];
        end else if (!serial_port_enable_r || arrive) begin
            single_receive_enable_r <= 1'b0;
        end
    end

    // ==========================================================
    // overrun flag: set wins over every clear
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            overrun_error_flag_r <= 1'b0;
        end else if (ovr_set) begin
            overrun_error_flag_r <= 1'b1;
        end else if (!serial_port_enable_r
                     || (wr_ctrl && !reg_wdata_in[`SMR_BIT_CONT])
                     || (pop && !continuous_receive_enable_r)) begin
            overrun_error_flag_r <= 1'b0;
        end
    end

    // ==========================================================
    // two-entry receive queue, flushed while the port is disabled
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in || !serial_port_enable_r) begin
            head_r  <= 1'b0;
            count_r <= 2'h0;
        end else begin
            if (push) begin
                fifo_mem_r[head_r ^ count_r[0]] <= link_char;
            end
            if (pop) begin
                head_r <= !head_r;
            end
            count_r <= count_r + {1'b0, push} - {1'b0, pop};
        end
    end

    // ==========================================================
    // read mux
    always_comb begin
        rd_val = `SMR_RST_BYTE;
        unique case (reg_addr_in)
            `SMR_ADDR_CTRL: begin
                rd_val[`SMR_BIT_PORT_EN]  = serial_port_enable_r;
                rd_val[`SMR_BIT_NINE_SEL] = nine_bit_receive_select_r;
                rd_val[`SMR_BIT_SINGLE]   = single_receive_enable_r;
                rd_val[`SMR_BIT_CONT]     = continuous_receive_enable_r;
                rd_val[`SMR_BIT_OVERRUN]  = overrun_error_flag_r;
                // ninth bit of the top unread character
                rd_val[`SMR_BIT_NINTH]    = nine_bit_receive_select_r && top_char[8];
            end
            `SMR_ADDR_DATA:  rd_val = top_char[7:0];
            `SMR_ADDR_DIVLO: rd_val = baud_divisor_low_r;
            `SMR_ADDR_DIVHI: rd_val = baud_divisor_high_r;
            `SMR_ADDR_MODE: begin
                rd_val[`SMR_BIT_CLK_MODE] = clocked_mode_r;
                rd_val[`SMR_BIT_CLK_SRC]  = clock_source_select_r;
                rd_val[`SMR_BIT_WIDE]     = wide_divisor_select_r;
                rd_val[`SMR_BIT_HS]       = high_speed_baud_select_r;
            end
            `SMR_ADDR_INTC: begin
                rd_val[`SMR_BIT_RX_IE]  = receive_int_enable_r;
                rd_val[`SMR_BIT_PER_IE] = peripheral_interrupt_enable_r;
                rd_val[`SMR_BIT_GLB_IE] = global_interrupt_enable_r;
                rd_val[`SMR_BIT_RX_IF]  = receive_int_flag;
            end
            default: rd_val = `SMR_RST_BYTE;
        endcase
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            reg_rdata_out <= `SMR_RST_BYTE;
        end else begin
            reg_rdata_out <= reg_rd_in ? rd_val : `SMR_RST_BYTE;
        end
    end

    // ==========================================================
    // run request, pin enables and interrupt output
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            run_r                  <= 1'b0;
            shift_clock_pin_oe_out <= 1'b0;
            data_pin_out           <= 1'b0;
            data_pin_oe_out        <= 1'b0;
            rx_irq_out             <= 1'b0;
        end else begin
            // master only with port enable, clocked mode and clock source all set
            shift_clock_pin_oe_out <= serial_port_enable_r && clocked_mode_r
                                      && clock_source_select_r;
            run_r <= serial_port_enable_r && clocked_mode_r && clock_source_select_r
                     && (single_receive_enable_r || continuous_receive_enable_r)
                     && !overrun_error_flag_r;
            // data pin driver stays off while receiving
            data_pin_out    <= 1'b0;
            data_pin_oe_out <= 1'b0;
            rx_irq_out <= receive_int_flag && receive_int_enable_r
                          && peripheral_interrupt_enable_r
                          && global_interrupt_enable_r;
        end
    end

    // ==========================================================
    // checks
    default clocking cb_sys @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);

    property p_irq_on;
        (receive_int_flag && receive_int_enable_r && peripheral_interrupt_enable_r
         && global_interrupt_enable_r) |=> rx_irq_out;
    endproperty
    a_irq_on: assert property (p_irq_on) else $error("interrupt not raised");

    property p_irq_off;
        (!global_interrupt_enable_r) |=> !rx_irq_out;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("interrupt leaks");

    property p_flag;
        push |=> receive_int_flag;
    endproperty
    a_flag: assert property (p_flag) else $error("receive flag not set");

    property p_pop;
        (rd_data && count_r == 2'h2 && !push) |=> (count_r == 2'h1);
    endproperty
    a_pop: assert property (p_pop) else $error("data read did not pop");

    property p_rdata;
        logic [7:0] v;
        (rd_data && receive_int_flag, v = top_char[7:0]) |=> (reg_rdata_out == v);
    endproperty
    a_rdata: assert property (p_rdata) else $error("wrong data byte");

    property p_ovr;
        ovr_set |=> (overrun_error_flag_r && count_r == 2'h2) ##1 !run_r;
    endproperty
    a_ovr: assert property (p_ovr) else $error("overrun handling wrong");

    property p_ovr_clr;
        (wr_ctrl && !reg_wdata_in[`SMR_BIT_CONT] && !ovr_set) |=> !overrun_error_flag_r;
    endproperty
    a_ovr_clr: assert property (p_ovr_clr) else $error("overrun not cleared");

    property p_single;
        (arrive && single_receive_enable_r && !wr_ctrl) |=> !single_receive_enable_r;
    endproperty
    a_single: assert property (p_single) else $error("single enable kept");

    property p_master;
        (!clocked_mode_r) |=> (!run_r && !shift_clock_pin_oe_out);
    endproperty
    a_master: assert property (p_master) else $error("clock driven in wrong mode");

    property p_ninth;
        logic n;
        (reg_rd_in && hit(reg_addr_in, `SMR_ADDR_CTRL) && nine_bit_receive_select_r,
         n = top_char[8]) |=> (reg_rdata_out[`SMR_BIT_NINTH] == n);
    endproperty
    a_ninth: assert property (p_ninth) else $error("ninth bit wrong");

    c_single: cover property (arrive && single_receive_enable_r);
    c_cont: cover property (push && continuous_receive_enable_r && count_r == 2'h1);
    c_ovr: cover property (ovr_set);
    c_nine: cover property (push && nine_bit_receive_select_r && link_char[8]);

endmodule : smr_sync_rx_top
`default_nettype wire

// ===== tb/smr_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// slave: shifts a word out lsb first on the master's clock
module smr_slave_model (
    input  wire logic       sclk_in,
    input  wire logic       load_in,
    input  wire logic [3:0] last_in,
    input  wire logic [8:0] word_in,
    output logic            data_out
);
    logic [3:0] idx_r;
    initial data_out = 1'b0;
    // next bit on the leading edge so it is valid at the trailing edge
    always @(posedge sclk_in or posedge load_in) begin
        if (load_in) begin
            idx_r <= 4'h0;
        end else begin
            data_out <= word_in[idx_r];
            idx_r    <= (idx_r == last_in) ? 4'h0 : idx_r + 4'h1;
        end
    end
    // hold time over: the line stops showing the bit
    always @(negedge sclk_in) data_out <= #10 ~data_out;
endmodule : smr_slave_model
`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// bench
module tb_top;
    logic mclk = 0, lclk = 0, rst = 1, wr = 0, rd = 0, ld = 0, din, sclk, oe, irq, dpo, dpoe;
    logic [2:0] addr = 0;
    logic [7:0] wd = 0, rdat;
    logic [8:0] word = 0;
    logic [3:0] last = 4'h7;
    int n_errors = 0, n_checks = 0, cyc = 0;
    always #10 mclk = ~mclk;
    initial #3 forever #6 lclk = ~lclk;
    smr_sync_rx_top smr_sync_rx_top_i (.mclk_in(mclk), .sys_rst_in(rst), .reg_addr_in(addr),
        .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdat),
        .link_clk_in(lclk), .data_pin_in(din), .data_pin_out(dpo), .data_pin_oe_out(dpoe),
        .shift_clock_pin_in(1'b0), .shift_clock_pin_out(sclk),
        .shift_clock_pin_oe_out(oe), .rx_irq_out(irq));
    smr_slave_model smr_slave_model_i (.sclk_in(sclk), .load_in(ld), .last_in(last),
        .word_in(word), .data_out(din));
    // ==========================================================
    // bus and compare tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk1(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t pin got %b expected %b", $time, got, exp);
        end
    endtask : chk1
    task automatic wreg(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk) {wr, addr, wd} <= {1'b1, a, d};
        @(posedge mclk) wr <= 1'b0;
    endtask : wreg
    task automatic rreg(input logic [2:0] a, input logic [7:0] exp);
        @(posedge mclk) {rd, addr} <= {1'b1, a};
        @(posedge mclk) rd <= 1'b0;
        #1 chk(rdat, exp);
    endtask : rreg
    task automatic end_of_test;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_of_test
    // ==========================================================
    // one character: start, wait for the request, read status then data
    task automatic recv(input logic [8:0] w, input logic [7:0] ctrl, input logic [7:0] st);
        int n;
        word = w;
        last = ctrl[6] ? 4'h8 : 4'h7;
        @(posedge mclk) ld <= 1'b1;
        @(posedge mclk) ld <= 1'b0;
        wreg(3'h0, ctrl);
        for (n = 0; n < 400 && irq !== 1'b1; n++) @(posedge mclk);
        chk1(irq, 1'b1);
        chk1(dpoe, 1'b0);
        chk1(dpo, 1'b0);
        rreg(3'h0, st);
        rreg(3'h1, w[7:0]);
        repeat (3) @(posedge mclk);
        chk1(irq, 1'b0);
    endtask : recv
    // ==========================================================
    // continuous receive dropped mid character: nothing delivered
    task automatic abort_cont;
        wreg(3'h0, 8'h90);
        repeat (12) @(posedge mclk);
        wreg(3'h0, 8'h80);
        repeat (60) @(posedge mclk);
        rreg(3'h5, 8'h07);
        chk1(sclk, 1'b0);
    endtask : abort_cont
    // ==========================================================
    // overrun in continuous mode with interrupts masked
    task automatic overrun;
        word = 9'h03C;
        last = 4'h7;
        @(posedge mclk) ld <= 1'b1;
        @(posedge mclk) ld <= 1'b0;
        wreg(3'h5, 8'h03);
        wreg(3'h3, 8'h00);
        wreg(3'h4, 8'h07);
        wreg(3'h0, 8'h90);
        repeat (300) @(posedge mclk);
        chk1(irq, 1'b0);
        rreg(3'h0, 8'h92);
        repeat (20) @(posedge mclk) chk1(sclk, 1'b0);
        rreg(3'h1, 8'h3C);
        rreg(3'h1, 8'h3C);
        wreg(3'h0, 8'h80);
        rreg(3'h0, 8'h80);
        rreg(3'h6, 8'h00);
    endtask : overrun
    // ==========================================================
    // main sequence
    always @(posedge mclk) if (++cyc == 20000) begin
        n_errors++;
        end_of_test();
    end
    initial begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        wreg(3'h2, 8'h03);
        wreg(3'h3, 8'h01);
        wreg(3'h4, 8'h03);
        wreg(3'h0, 8'h80);
        repeat (3) @(posedge mclk);
        chk1(oe, 1'b1);
        wreg(3'h5, 8'h07);
        recv(9'h0A5, 8'hA0, 8'h80);
        recv(9'h15A, 8'hE0, 8'hC1);
        abort_cont();
        overrun();
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
